// ### rtl/acc_pkg.sv
// Package: register map, field positions and codes for the comparator control block
package acc_pkg;
  localparam int NUM_CMP = 4;
  // Byte offsets on the APB bus
  localparam logic [11:0] CTRL0_OFS = 12'h000;
  localparam logic [11:0] CTRL1_OFS = 12'h004;
  localparam logic [11:0] CTRL2_OFS = 12'h008;
  localparam logic [11:0] CTRL3_OFS = 12'h00c;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  localparam logic [11:0] MASK_OFS = 12'h014;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h018;
  localparam logic [11:0] SYSCTL_OFS = 12'h01c;
  localparam logic [11:0] ROUTE_OFS = 12'h020;
  localparam logic [11:0] TRIG_ACK_OFS = 12'h024;
  // Control register fields
  localparam int EN_BIT = 7;
  localparam int IE_BIT = 6;
  localparam int EVSEL_HI = 5;
  localparam int EVSEL_LO = 4;
  localparam int CLKSEL_BIT = 3;
  localparam int CAPT_BIT = 3;
  localparam int NEGSEL_HI = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_RSV_MASK = 8'hf7;
  // System control fields (timer edge/mask, adc reference)
  localparam int SYS_CAPT_MASK_BIT = 0;
  localparam int SYS_CAPT_EDGE_BIT = 1;
  localparam int SYS_REF_LO = 2;
  localparam logic [3:0] SYSCTL_RST = 4'h0;
  localparam logic [2:0] ROUTE_RST = 3'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Event select codes
  typedef enum logic [1:0] {
    ACC_EV_TOGGLE = 2'b00,
    ACC_EV_RSVD = 2'b01,
    ACC_EV_FALL = 2'b10,
    ACC_EV_RISE = 2'b11
  } acc_evsel_t;
  localparam logic [2:0] NEG_RSVD = 3'b111;
endpackage : acc_pkg

// ### rtl/acc_evt_if.sv
// Interface: per-comparator sample, configuration and event between top and edge unit
`timescale 1ns/1ps
interface acc_evt_if #(parameter int N = 4);
  logic [N-1:0] sample;
  logic [N-1:0] enable;
  logic [2*N-1:0] evsel;
  logic [N-1:0] event_p;
  logic [N-1:0] result;
  modport top (output sample, output enable, output evsel, input event_p, input result);
  modport unit (input sample, input enable, input evsel, output event_p, output result);
endinterface : acc_evt_if

// ### rtl/acc_edge_unit.sv
// Edge unit: registers comparator samples and flags the selected output events
`timescale 1ns/1ps
module acc_edge_unit #(
  parameter int N = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  acc_evt_if.unit ev
);
  logic [N-1:0] prev_ff;
  logic [N-1:0] cur_ff;

  // Current sample and previous sample, both on the comparator clock
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_ff <= '0;
      prev_ff <= '0;
    end else begin
      cur_ff <= ev.sample & ev.enable;
      prev_ff <= cur_ff;
    end
  end

  assign ev.result = cur_ff;

  generate
    for (genvar i = 0; i < N; i++) begin : g_ev
      logic [1:0] sel;
      logic rise;
      logic fall;
      assign sel = ev.evsel[2*i +: 2];
      assign rise = cur_ff[i] & ~prev_ff[i];
      assign fall = ~cur_ff[i] & prev_ff[i];
      always_comb begin
        unique case (sel)
          acc_pkg::ACC_EV_TOGGLE: ev.event_p[i] = rise | fall;
          acc_pkg::ACC_EV_FALL: ev.event_p[i] = fall;
          acc_pkg::ACC_EV_RISE: ev.event_p[i] = rise;
          // Reserved code raises nothing
          default: ev.event_p[i] = 1'b0;
        endcase
      end

      chk_rise_event: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (sel == acc_pkg::ACC_EV_RISE && cur_ff[i] && !prev_ff[i]) |-> ev.event_p[i])
        else $error("rising event missed");
      chk_no_rsvd_event: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (sel == acc_pkg::ACC_EV_RSVD) |-> !ev.event_p[i])
        else $error("reserved event code raised event");
    end
  endgenerate
endmodule : acc_edge_unit

// ### rtl/acc_top.sv
// Top: APB register file and control for four clocked analog comparators
//
// Summary of operation
// - Four comparators each report a result bit that is high while the positive input exceeds the chosen negative input.
// - Control bit 7 switches its comparator on when set and off when clear.
// - Control bit 6 lets that comparator's own interrupt through when set and blocks it when clear.
// - Control bits 5:4 pick the event: 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Control bits 2:0 pick the negative input: four reference fractions, bandgap, DAC, external pin, 111 reserved.
// - The internal reference fractions come from the reference chosen by the ADC reference select.
// - Bit 3 of comparator 0 control selects the PLL clock when set and the I/O clock when clear.
// - Comparator flags are offered as triggers for ADC or DAC conversions.
// - With the capture route on, comparator 1's result feeds the timer capture front end.
// - A capture interrupt from the comparator occurs only while the timer capture mask is set.
// - The capture event is a rising result edge when the timer edge select is 1, falling when 0.
// - With the capture route off, the comparator has no path to the timer capture.
// - An amplifier route bit moves comparator 0, 1 or 2 positive input to the amplifier and doubles its clock ratio.
// - Flags set on the chosen event and clear on vector execution with interrupt enabled or a written one.
`timescale 1ns/1ps
module acc_top #(
  parameter int N = acc_pkg::NUM_CMP
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [N-1:0] cmp_raw_in,
  input wire logic [N-1:0] vector_ack_in,
  output logic [N-1:0] cmp_enable_out,
  output logic [3*N-1:0] cmp_neg_sel_out,
  output logic [1:0] cmp_ref_sel_out,
  output logic cmp_clk_pll_sel_out,
  output logic [2:0] amp_route_out,
  output logic [N-1:0] cmp_irq_req_out,
  output logic [N-1:0] conv_trigger_out,
  output logic capture_in_out,
  output logic capture_route_on_out,
  output logic capture_irq_out,
  output logic irq_out
);
  logic [7:0] ctrl_ff [N];
  logic [N-1:0] flag_ff;
  logic [N-1:0] mask_ff;
  logic [3:0] sys_ff;
  logic [2:0] route_ff;
  logic cap_prev_ff;
  logic capture_irq_ff;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [N-1:0] wr_clr;
  logic [N-1:0] ack_clr;
  logic [N-1:0] ie_vec;
  logic [31:0] nxt_rdata;
  logic cap_src;
  logic cap_edge;
  acc_evt_if #(.N(N)) ev ();

  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & penable_in & ~pwrite_in;
  // Zero-wait slave: every access completes in its first access cycle
  assign pready_out = 1'b1;

  always_comb begin
    hit = 1'b1;
    unique case (paddr_in)
      acc_pkg::CTRL0_OFS, acc_pkg::CTRL1_OFS, acc_pkg::CTRL2_OFS, acc_pkg::CTRL3_OFS,
      acc_pkg::STATUS_OFS, acc_pkg::MASK_OFS, acc_pkg::IRQ_STAT_OFS,
      acc_pkg::SYSCTL_OFS, acc_pkg::ROUTE_OFS, acc_pkg::TRIG_ACK_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr_out = psel_in & penable_in & ~hit;

  // Control registers; bit 3 only exists in comparators 0 and 1
  generate
    for (genvar i = 0; i < N; i++) begin : g_ctrl
      logic [11:0] ofs;
      assign ofs = acc_pkg::CTRL0_OFS + 12'(4 * i);
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ctrl_ff[i] <= acc_pkg::CTRL_RST;
        end else if (wr_en && paddr_in == ofs) begin
          ctrl_ff[i] <= (i < 2) ? pwdata_in[7:0] : (pwdata_in[7:0] & acc_pkg::CTRL_RSV_MASK);
        end
      end
      assign cmp_enable_out[i] = ctrl_ff[i][acc_pkg::EN_BIT];
      assign ie_vec[i] = ctrl_ff[i][acc_pkg::IE_BIT];
      assign ev.evsel[2*i +: 2] = ctrl_ff[i][acc_pkg::EVSEL_HI:acc_pkg::EVSEL_LO];
      assign cmp_neg_sel_out[3*i +: 3] = ctrl_ff[i][acc_pkg::NEGSEL_HI:0];
    end
  endgenerate

  assign ev.sample = cmp_raw_in;
  assign ev.enable = cmp_enable_out;
  assign cmp_clk_pll_sel_out = ctrl_ff[0][acc_pkg::CLKSEL_BIT];

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_ff <= acc_pkg::SYSCTL_RST;
    end else if (wr_en && paddr_in == acc_pkg::SYSCTL_OFS) begin
      sys_ff <= pwdata_in[3:0];
    end
  end
  assign cmp_ref_sel_out = sys_ff[acc_pkg::SYS_REF_LO +: 2];

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_ff <= acc_pkg::ROUTE_RST;
    end else if (wr_en && paddr_in == acc_pkg::ROUTE_OFS) begin
      route_ff <= pwdata_in[2:0];
    end
  end
  // Analog side swaps the positive input and runs the 2x clock ratio
  assign amp_route_out = route_ff;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_ff <= acc_pkg::MASK_RST;
    end else if (wr_en && paddr_in == acc_pkg::MASK_OFS) begin
      mask_ff <= pwdata_in[N-1:0];
    end
  end

  acc_edge_unit #(.N(N)) u_edge (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ev(ev.unit)
  );

  // Flags: writing one to STATUS clears, as does a vector ack with interrupt on
  assign wr_clr = (wr_en && paddr_in == acc_pkg::STATUS_OFS) ? pwdata_in[N+3:4] : '0;
  assign ack_clr = vector_ack_in & ie_vec;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_ff <= '0;
    end else begin
      // A new event in the clearing cycle keeps the flag set
      flag_ff <= (flag_ff & ~(wr_clr | ack_clr)) | ev.event_p;
    end
  end
  assign cmp_irq_req_out = flag_ff & ie_vec;
  assign conv_trigger_out = flag_ff;

  // Capture path: no route bit, no path at all
  assign cap_src = ctrl_ff[1][acc_pkg::CAPT_BIT] & ev.result[1];
  assign capture_in_out = cap_src;
  assign capture_route_on_out = ctrl_ff[1][acc_pkg::CAPT_BIT];
  assign cap_edge = sys_ff[acc_pkg::SYS_CAPT_EDGE_BIT] ? (cap_src & ~cap_prev_ff)
                                                      : (~cap_src & cap_prev_ff);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_prev_ff <= 1'b0;
    end else begin
      cap_prev_ff <= cap_src;
    end
  end

  // Sticky capture interrupt; a read of IRQ_STAT clears it, a new edge wins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_irq_ff <= 1'b0;
    end else if (cap_edge && ctrl_ff[1][acc_pkg::CAPT_BIT]
                 && sys_ff[acc_pkg::SYS_CAPT_MASK_BIT]) begin
      capture_irq_ff <= 1'b1;
    end else if (rd_en && paddr_in == acc_pkg::IRQ_STAT_OFS) begin
      capture_irq_ff <= 1'b0;
    end
  end
  assign capture_irq_out = capture_irq_ff;

  assign irq_out = |(flag_ff & mask_ff);

  always_comb begin
    nxt_rdata = '0;
    unique case (paddr_in)
      acc_pkg::CTRL0_OFS: nxt_rdata[7:0] = ctrl_ff[0];
      acc_pkg::CTRL1_OFS: nxt_rdata[7:0] = ctrl_ff[1];
      acc_pkg::CTRL2_OFS: nxt_rdata[7:0] = ctrl_ff[2];
      acc_pkg::CTRL3_OFS: nxt_rdata[7:0] = ctrl_ff[3];
      acc_pkg::STATUS_OFS: nxt_rdata[7:0] = {flag_ff, ev.result};
      acc_pkg::MASK_OFS: nxt_rdata[N-1:0] = mask_ff;
      acc_pkg::IRQ_STAT_OFS: nxt_rdata[0] = capture_irq_ff;
      acc_pkg::SYSCTL_OFS: nxt_rdata[3:0] = sys_ff;
      acc_pkg::ROUTE_OFS: nxt_rdata[2:0] = route_ff;
      default: nxt_rdata = '0;
    endcase
  end
  // Combinational read data keeps the zero-wait answer
  assign prdata_out = rd_en ? nxt_rdata : '0;

  chk_flag_sets: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    |ev.event_p |=> |flag_ff)
    else $error("event did not set flag");
  chk_irq_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ((cmp_irq_req_out & ~ie_vec) == '0))
    else $error("interrupt request without enable");
  chk_capture_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !ctrl_ff[1][acc_pkg::CAPT_BIT] |-> !capture_in_out)
    else $error("capture path active while route off");
  chk_cap_mask: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(capture_irq_ff) |-> $past(sys_ff[acc_pkg::SYS_CAPT_MASK_BIT]))
    else $error("capture irq without mask");
  chk_disabled_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !cmp_enable_out[0] [*2] |=> !ev.result[0])
    else $error("disabled comparator reports result");
  chk_ack_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (flag_ff[0] && vector_ack_in[0] && ie_vec[0] && !ev.event_p[0]) |=> !flag_ff[0])
    else $error("vector ack did not clear flag");
  chk_rise_capture: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (sys_ff[acc_pkg::SYS_CAPT_MASK_BIT] && sys_ff[acc_pkg::SYS_CAPT_EDGE_BIT]
     && $rose(cap_src)) |=> capture_irq_ff)
    else $error("rising capture edge missed");
  chk_sample_lag: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmp_enable_out[1] |=> ev.result[1] == $past(cmp_raw_in[1]))
    else $error("result not sampled from input");
endmodule : acc_top

// ### dv/acc_cmp_model.sv
// Behavioural model of the four clocked analog comparator cores
`timescale 1ns/1ps
module acc_cmp_model #(
  parameter int N = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [N-1:0] enable_in,
  input wire logic [N-1:0] pos_above_in,
  output logic [N-1:0] raw_out
);
  // A core that is switched off rests low, as the idle analog output does
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      raw_out <= '0;
    end else begin
      raw_out <= enable_in & pos_above_in;
    end
  end
endmodule // acc_cmp_model

// ### dv/acc_top_test.sv
// Testbench: register, event, interrupt and capture checks for the comparator control block
`timescale 1ns/1ps
module acc_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, e, f;
  logic [3:0] raw, ack = 4'h0, above = 4'h0, en, irq_req, trig;
  logic [11:0] neg;
  logic [1:0] ref_sel, m;
  logic [2:0] amp;
  logic pll_sel, cap_in, cap_on, cap_irq, irq;
  logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h3};
  int err_total = 0, n_checks = 0, cyc = 0;

  acc_top i_acc_top (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .cmp_raw_in(raw),
    .vector_ack_in(ack), .cmp_enable_out(en), .cmp_neg_sel_out(neg),
    .cmp_ref_sel_out(ref_sel), .cmp_clk_pll_sel_out(pll_sel), .amp_route_out(amp),
    .cmp_irq_req_out(irq_req), .conv_trigger_out(trig), .capture_in_out(cap_in),
    .capture_route_on_out(cap_on), .capture_irq_out(cap_irq), .irq_out(irq));
  acc_cmp_model i_acc_cmp_model (.ref_clk_in(clk), .rst_n_in(rst_n), .enable_in(en),
    .pos_above_in(above), .raw_out(raw));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Bounded so a hung bus or a stuck wait still reaches the report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer: setup, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    logic rdy;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken as it stands before the completing edge, not after it
    do begin
      @(negedge clk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      @(posedge clk);
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic y;
    xfer(1'b1, a, wd, x, y);
  endtask

  task automatic pulse_ack();
    ack <= 4'h1;
    @(posedge clk);
    ack <= 4'h0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer(1'b0, acc_pkg::CTRL1_OFS, 32'h0, d, e);
    chk("ctrl1 reset", d, 32'h0);
    wr(acc_pkg::CTRL0_OFS, 32'hee);
    xfer(1'b0, acc_pkg::CTRL0_OFS, 32'h0, d, e);
    chk("ctrl0 rw", d, 32'hee);
    chk("pins", {pll_sel, en, neg[2:0]}, {1'h1, 4'h1, 3'h6});
    wr(acc_pkg::CTRL2_OFS, 32'hee);
    xfer(1'b0, acc_pkg::CTRL2_OFS, 32'h0, d, e);
    chk("ctrl2 bit3", d, 32'he6);
    wr(acc_pkg::CTRL2_OFS, 32'h0);
    xfer(1'b0, 12'h0f0, 32'h0, d, e);
    chk("unmapped", {d[30:0], e}, 32'h1);
    wr(acc_pkg::SYSCTL_OFS, 32'hc);
    wr(acc_pkg::ROUTE_OFS, 32'h5);
    chk("ref amp", {ref_sel, amp}, {2'h3, 3'h5});
    wr(acc_pkg::MASK_OFS, 32'h1);
    wr(acc_pkg::STATUS_OFS, 32'hf0);
    for (int i = 0; i < 3; i++) begin
      m = modes[i];
      wr(acc_pkg::CTRL0_OFS, {24'h0, 2'h3, m, 4'h0});
      above[0] <= 1'b1;
      repeat (4) @(posedge clk);
      f = (m != 2'h2);
      chk("irq rise", {irq_req[0], irq, trig[0]}, {3{f}});
      xfer(1'b0, acc_pkg::STATUS_OFS, 32'h0, d, e);
      chk("status rise", d, {27'h0, f, 4'h1});
      wr(acc_pkg::STATUS_OFS, 32'h10);
      above[0] <= 1'b0;
      repeat (4) @(posedge clk);
      xfer(1'b0, acc_pkg::STATUS_OFS, 32'h0, d, e);
      chk("status fall", d, {27'h0, m != 2'h3, 4'h0});
      wr(acc_pkg::STATUS_OFS, 32'h10);
    end
    wr(acc_pkg::CTRL0_OFS, 32'hb0);
    wr(acc_pkg::MASK_OFS, 32'h0);
    above[0] <= 1'b1;
    repeat (4) @(posedge clk);
    chk("gated", {irq_req[0], irq, trig[0]}, 32'h1);
    pulse_ack();
    chk("ack no ie", {31'h0, trig[0]}, 32'h1);
    wr(acc_pkg::CTRL0_OFS, 32'hf0);
    pulse_ack();
    chk("ack ie", {31'h0, trig[0]}, 32'h0);
    wr(acc_pkg::SYSCTL_OFS, 32'h3);
    wr(acc_pkg::CTRL1_OFS, 32'h88);
    above[1] <= 1'b1;
    repeat (10) @(posedge clk);
    chk("capture path", {cap_on, cap_in}, 32'h3);
    xfer(1'b0, acc_pkg::IRQ_STAT_OFS, 32'h0, d, e);
    chk("capture irq", d, 32'h1);
    xfer(1'b0, acc_pkg::IRQ_STAT_OFS, 32'h0, d, e);
    chk("capture clr", {d[30:0], cap_irq}, 32'h0);
    wr(acc_pkg::CTRL1_OFS, 32'h80);
    above[1] <= 1'b0;
    repeat (4) @(posedge clk);
    above[1] <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(1'b0, acc_pkg::IRQ_STAT_OFS, 32'h0, d, e);
    chk("route off", {d[29:0], cap_on, cap_in}, 32'h0);
    end_of_test();
  end
endmodule // acc_top_test
